// [logic/jcb_code_dma.sv]
// Purpose: Code buffer DMA engine between the codec code port and host memory.
// Assumes: Codec status pulses come from logic on clk; memory answers with mem_ack.
// Notes: How it works list below; one memory access outstanding at a time.
// How it works
// - Compress moves codec words to memory; decompress moves memory words to codec.
// - frame_mode picks one field or two fields per buffer.
// - Four table entries, base taken from the table base input.
// - Entry points to a fragment list; chunk addresses come from that list.
// - Entry bit 0 low is host command, high is engine status.
// - Status holds count 31:24, zero 23, byte length 22:1, one in bit 0.
// - Fragment entry is address word plus length 20:1 and final flag.
// - Compression starts filling the first buffer's fragments.
// - Compress success writes status, pulses interrupt, starts next unit.
// - Compress re-reads a status entry until the host frees it.
// - Fail on final fragment full, strip overflow, or late vertical sync, except while the unit's last word is being written.
// - Failed compression: no interrupt, entry untouched, retry same buffer.
// - Decompress done sets entry bit 0, pulses interrupt, reads next entry.
// - Hardware reset clears hold bit; engine idles until software sets it.
// - Decompress with no free buffer repeats the last available buffer.
`timescale 1ns/100ps
module jcb_code_dma (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic hold_write,
  input wire logic hold_value,
  output logic global_hold_control,
  input wire logic process_reset,
  input wire logic compress_mode,
  input wire logic frame_mode,
  input wire logic [31:0] buffer_table_base_register,
  input wire logic vsync_trail,
  input wire logic strip_overflow,
  input wire logic [31:0] code_in_data,
  input wire logic code_in_last,
  input wire logic code_in_valid,
  output logic code_in_ready,
  output logic [31:0] code_out_data,
  output logic code_out_valid,
  input wire logic code_out_ready,
  output logic mem_req,
  output logic mem_we,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  output logic irq,
  output logic [7:0] field_serial_count,
  output logic [jcb_pkg::IDX_W-1:0] buffer_index,
  output logic busy
);
  jcb_pkg::jcb_state_e state;
  logic engine_rst;
  logic [31:0] table_base;
  logic [31:0] entry_word;
  logic [31:0] last_list_ptr;
  logic have_last;
  logic repeat_unit;
  logic [31:0] list_ptr;
  logic [31:0] frag_addr;
  logic frag_final;
  logic [jcb_pkg::FRAG_LEN_W-1:0] frag_len;
  logic cur_load;
  logic cur_step;
  logic [31:0] cur_addr;
  logic cur_empty;
  logic [jcb_pkg::FRAG_LEN_W-1:0] word_count;
  logic [jcb_pkg::FIELDS_W-1:0] fields_left;
  logic [jcb_pkg::FIELDS_W-1:0] vs_count;
  logic last_word;
  logic fail_pend;
  logic in_unit;
  logic vs_fail;
  logic fail_now;
  logic [jcb_pkg::FIELDS_W-1:0] fields_needed;
  logic [31:0] entry_addr;
  logic [31:0] next_entry_addr;
  logic [31:0] status_word;
  logic [31:0] consumed_word;
  logic [jcb_pkg::FRAG_LEN_W-1:0] rd_len;

  // Byte address of a table entry
  function automatic logic [31:0] entry_at(input logic [31:0] base,
                                           input logic [jcb_pkg::IDX_W-1:0] idx);
    entry_at = base + 32'(idx) * jcb_pkg::ENTRY_BYTES;
  endfunction

  // Global hold bit: cleared by hardware reset, then software owned
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      global_hold_control <= 1'b0;
    else if (hold_write)
      global_hold_control <= hold_value;
  end

  // Engine idles in soft reset or process reset
  assign engine_rst = sys_rst | ~global_hold_control | process_reset;

  // Decoded terms
  assign fields_needed = frame_mode ? jcb_pkg::FIELDS_PER_FRAME
                                    : jcb_pkg::FIELDS_PER_FIELD;
  assign entry_addr = entry_at(table_base, buffer_index);
  assign next_entry_addr = entry_at(table_base, buffer_index + jcb_pkg::IDX_W'(1));
  // Length includes the word whose write is being acknowledged
  assign status_word = {field_serial_count, 1'b0,
                        word_count + jcb_pkg::FRAG_LEN_W'(1), 2'b00, 1'b1};
  assign consumed_word = {entry_word[31:jcb_pkg::PTR_LSB], 1'b0, 1'b1};
  assign rd_len = mem_rdata[jcb_pkg::FRAG_LEN_LSB +: jcb_pkg::FRAG_LEN_W];
  assign in_unit = compress_mode && (state == jcb_pkg::ST_FRAG_A
    || state == jcb_pkg::ST_FRAG_L || state == jcb_pkg::ST_NEXT
    || state == jcb_pkg::ST_IN || state == jcb_pkg::ST_WR);
  // A sync edge beyond the unit's own fields means the codec ran late
  assign vs_fail = in_unit && vsync_trail && (vs_count >= fields_needed);
  assign fail_now = fail_pend | vs_fail | (in_unit & strip_overflow);
  assign code_in_ready = (state == jcb_pkg::ST_IN && !fail_now)
                         || state == jcb_pkg::ST_DRAIN;
  assign code_out_valid = (state == jcb_pkg::ST_OUT);
  assign busy = (state != jcb_pkg::ST_IDLE);
  assign cur_step = (state == jcb_pkg::ST_WR || state == jcb_pkg::ST_RD) && mem_ack;

  jcb_frag_cursor #(
    .LEN_W(jcb_pkg::FRAG_LEN_W)
  ) u_cursor (
    .clk(clk),
    .rst(engine_rst),
    .load(cur_load),
    .load_addr(frag_addr),
    .load_len(frag_len),
    .step(cur_step),
    .cur_addr(cur_addr),
    .empty(cur_empty)
  );

  // Failure flag is held until no memory access is in flight
  always_ff @(posedge clk)
  begin
    if (engine_rst || state == jcb_pkg::ST_DRAIN || state == jcb_pkg::ST_ENT_RD)
      fail_pend <= 1'b0;
    else if (vs_fail || (in_unit && strip_overflow))
      fail_pend <= 1'b1;
  end

  // Sync edges seen during the current unit
  always_ff @(posedge clk)
  begin
    if (engine_rst || state == jcb_pkg::ST_ENT_RD)
      vs_count <= '0;
    else if (in_unit && vsync_trail && vs_count < fields_needed)
      vs_count <= vs_count + jcb_pkg::FIELDS_W'(1);
  end

  // Main sequencer; memory outputs are registered and held until mem_ack
  always_ff @(posedge clk)
  begin
    if (engine_rst)
    begin
      state <= jcb_pkg::ST_IDLE;
      table_base <= jcb_pkg::WORD_ZERO;
      buffer_index <= '0;
      entry_word <= jcb_pkg::WORD_ZERO;
      last_list_ptr <= jcb_pkg::WORD_ZERO;
      have_last <= 1'b0;
      repeat_unit <= 1'b0;
      list_ptr <= jcb_pkg::WORD_ZERO;
      frag_addr <= jcb_pkg::WORD_ZERO;
      frag_len <= '0;
      frag_final <= 1'b0;
      cur_load <= 1'b0;
      word_count <= '0;
      fields_left <= '0;
      last_word <= 1'b0;
      field_serial_count <= jcb_pkg::FCNT_RESET;
      code_out_data <= jcb_pkg::WORD_ZERO;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= jcb_pkg::WORD_ZERO;
      mem_wdata <= jcb_pkg::WORD_ZERO;
      irq <= 1'b0;
    end
    else
    begin
      cur_load <= 1'b0;
      irq <= 1'b0;
      case (state)
        jcb_pkg::ST_IDLE:
        begin
          table_base <= buffer_table_base_register;
          buffer_index <= '0;
          mem_req <= 1'b1;
          mem_we <= 1'b0;
          mem_addr <= buffer_table_base_register;
          state <= jcb_pkg::ST_ENT_RD;
        end
        jcb_pkg::ST_ENT_RD:
        begin
          word_count <= '0;
          fields_left <= fields_needed;
          if (mem_ack && !mem_rdata[jcb_pkg::STAT_BIT])
          begin
            entry_word <= mem_rdata;
            list_ptr <= {mem_rdata[31:jcb_pkg::PTR_LSB], 2'b00};
            last_list_ptr <= {mem_rdata[31:jcb_pkg::PTR_LSB], 2'b00};
            have_last <= 1'b1;
            repeat_unit <= 1'b0;
            mem_addr <= {mem_rdata[31:jcb_pkg::PTR_LSB], 2'b00};
            state <= jcb_pkg::ST_FRAG_A;
          end
          else if (mem_ack && !compress_mode && have_last)
          begin
            repeat_unit <= 1'b1;
            list_ptr <= last_list_ptr;
            mem_addr <= last_list_ptr;
            state <= jcb_pkg::ST_FRAG_A;
          end
          // Otherwise mem_req stays high and the entry is read again
        end
        jcb_pkg::ST_FRAG_A:
        begin
          if (mem_ack)
          begin
            frag_addr <= {mem_rdata[31:jcb_pkg::PTR_LSB], 2'b00};
            mem_addr <= list_ptr + jcb_pkg::FRAG_LEN_OFFSET;
            state <= jcb_pkg::ST_FRAG_L;
          end
        end
        jcb_pkg::ST_FRAG_L:
        begin
          if (mem_ack)
          begin
            frag_len <= rd_len;
            frag_final <= mem_rdata[jcb_pkg::FINAL_BIT];
            cur_load <= 1'b1;
            list_ptr <= list_ptr + jcb_pkg::FRAG_ENTRY_BYTES;
            mem_req <= 1'b0;
            state <= jcb_pkg::ST_NEXT;
          end
        end
        jcb_pkg::ST_NEXT:
        begin
          if (cur_load)
            state <= jcb_pkg::ST_NEXT; // Cursor settles one cycle after load
          else if (compress_mode && fail_now)
          begin
            field_serial_count <= field_serial_count + 8'h01;
            state <= jcb_pkg::ST_DRAIN;
          end
          else if (!cur_empty)
          begin
            mem_addr <= cur_addr;
            mem_we <= 1'b0;
            mem_req <= !compress_mode;
            state <= compress_mode ? jcb_pkg::ST_IN : jcb_pkg::ST_RD;
          end
          else if (!frag_final)
          begin
            mem_req <= 1'b1; // Fetch next fragment entry
            mem_we <= 1'b0;
            mem_addr <= list_ptr;
            state <= jcb_pkg::ST_FRAG_A;
          end
          else if (compress_mode)
          begin
            field_serial_count <= field_serial_count + 8'h01;
            state <= jcb_pkg::ST_DRAIN;
          end
          else if (repeat_unit)
          begin
            field_serial_count <= field_serial_count + 8'h01;
            mem_req <= 1'b1;
            mem_addr <= entry_addr;
            state <= jcb_pkg::ST_ENT_RD;
          end
          else
          begin
            mem_req <= 1'b1;
            mem_we <= 1'b1;
            mem_addr <= entry_addr;
            mem_wdata <= consumed_word;
            state <= jcb_pkg::ST_STAT;
          end
        end
        jcb_pkg::ST_IN:
        begin
          if (fail_now)
          begin
            field_serial_count <= field_serial_count + 8'h01;
            state <= jcb_pkg::ST_DRAIN;
          end
          else if (code_in_valid)
          begin
            mem_req <= 1'b1;
            mem_we <= 1'b1;
            mem_wdata <= code_in_data;
            last_word <= code_in_last;
            state <= jcb_pkg::ST_WR;
          end
        end
        jcb_pkg::ST_WR:
        begin
          if (mem_ack)
          begin
            mem_req <= 1'b0;
            word_count <= word_count + jcb_pkg::FRAG_LEN_W'(1);
            if (last_word && fields_left > jcb_pkg::FIELDS_W'(1))
            begin
              fields_left <= fields_left - jcb_pkg::FIELDS_W'(1);
              state <= jcb_pkg::ST_NEXT;
            end
            else if (last_word)
            begin
              mem_req <= 1'b1;
              mem_addr <= entry_addr;
              mem_wdata <= status_word;
              state <= jcb_pkg::ST_STAT;
            end
            else
              state <= jcb_pkg::ST_NEXT;
          end
        end
        jcb_pkg::ST_RD:
        begin
          if (mem_ack)
          begin
            mem_req <= 1'b0;
            code_out_data <= mem_rdata;
            state <= jcb_pkg::ST_OUT;
          end
        end
        jcb_pkg::ST_OUT:
        begin
          if (code_out_ready)
            state <= jcb_pkg::ST_NEXT;
        end
        jcb_pkg::ST_STAT:
        begin
          if (mem_ack)
          begin
            irq <= 1'b1;
            field_serial_count <= field_serial_count + 8'h01;
            buffer_index <= buffer_index + jcb_pkg::IDX_W'(1);
            mem_we <= 1'b0;
            mem_addr <= next_entry_addr;
            state <= jcb_pkg::ST_ENT_RD;
          end
        end
        jcb_pkg::ST_DRAIN:
        begin
          // Discard the rest of the failed unit, then retry the same entry
          if (code_in_valid && code_in_last && fields_left > jcb_pkg::FIELDS_W'(1))
            fields_left <= fields_left - jcb_pkg::FIELDS_W'(1);
          else if (code_in_valid && code_in_last)
          begin
            mem_req <= 1'b1;
            mem_we <= 1'b0;
            mem_addr <= entry_addr;
            state <= jcb_pkg::ST_ENT_RD;
          end
        end
        default:
          state <= jcb_pkg::ST_IDLE;
      endcase
    end
  end
endmodule

// [logic/jcb_pkg.sv]
// Purpose: Shared constants and state type of the code buffer DMA engine.
// Assumes: 32-bit host memory words, byte addresses.
// Notes: Table entry and fragment entry field positions live here; the status word itself is packed in jcb_code_dma.
package jcb_pkg;
  localparam int NUM_BUFFERS = 4;
  localparam int IDX_W = 2;
  localparam int FRAG_LEN_W = 20;
  localparam int FIELDS_W = 2;
  localparam logic [31:0] ENTRY_BYTES = 32'h4;
  localparam logic [31:0] FRAG_ENTRY_BYTES = 32'h8;
  localparam logic [31:0] FRAG_LEN_OFFSET = 32'h4;
  localparam logic [31:0] WORD_BYTES = 32'h4;
  localparam int STAT_BIT = 0;
  localparam int PTR_LSB = 2;
  localparam int FCNT_LSB = 24;
  localparam int LEN_LSB = 1;
  localparam int FRAG_LEN_LSB = 1;
  localparam int FINAL_BIT = 0;
  localparam logic [1:0] FIELDS_PER_FIELD = 2'h1;
  localparam logic [1:0] FIELDS_PER_FRAME = 2'h2;
  localparam logic [7:0] FCNT_RESET = 8'h00;
  localparam logic [31:0] WORD_ZERO = 32'h0;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ENT_RD,
    ST_FRAG_A,
    ST_FRAG_L,
    ST_NEXT,
    ST_IN,
    ST_WR,
    ST_RD,
    ST_OUT,
    ST_STAT,
    ST_DRAIN
  } jcb_state_e;
endpackage

// [logic/jcb_frag_cursor.sv]
// Purpose: Walks one memory fragment word by word.
// Assumes: Fragment start is doubleword aligned.
// Notes: A zero length loads as already empty.
`timescale 1ns/100ps
module jcb_frag_cursor #(
  parameter int LEN_W = jcb_pkg::FRAG_LEN_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic load,
  input wire logic [31:0] load_addr,
  input wire logic [LEN_W-1:0] load_len,
  input wire logic step,
  output logic [31:0] cur_addr,
  output logic empty
);
  logic [LEN_W-1:0] left;

  assign empty = (left == '0);

  // Load wins over step; a step on an empty cursor is ignored
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cur_addr <= jcb_pkg::WORD_ZERO;
      left <= '0;
    end
    else if (load)
    begin
      cur_addr <= load_addr;
      left <= load_len;
    end
    else if (step && !empty)
    begin
      cur_addr <= cur_addr + jcb_pkg::WORD_BYTES;
      left <= left - LEN_W'(1);
    end
  end
endmodule

// [test/jcb_code_dma_assertions.sv]
// Purpose: Port-level timing checks of the code buffer DMA engine.
// Assumes: One clock; sys_rst synchronous, active high.
// Notes: Bound into every jcb_code_dma instance at the foot of this file.
`timescale 1ns/100ps
module jcb_code_dma_checker (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic global_hold_control,
  input wire logic process_reset,
  input wire logic compress_mode,
  input wire logic [31:0] buffer_table_base_register,
  input wire logic code_in_ready,
  input wire logic [31:0] code_out_data,
  input wire logic code_out_valid,
  input wire logic code_out_ready,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic irq,
  input wire logic [7:0] field_serial_count,
  input wire logic [1:0] buffer_index
);
  // Engine runs only with the hold bit set and no process reset
  wire run = global_hold_control && !process_reset;
  wire rn = run && !sys_rst;
  wire [31:0] ent = buffer_table_base_register + {28'h0, buffer_index, 2'h0};
  wire ent_wr = run && mem_req && mem_we && mem_addr == ent;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_hold_clr; $past(sys_rst) |-> !global_hold_control; endproperty
  a_hold_clr: assert property (p_hold_clr) else $error("hold bit set after reset");
  property p_idle; !global_hold_control |=> !mem_req && !irq; endproperty
  a_idle: assert property (p_idle) else $error("engine active while held");
  property p_prst; process_reset |=> !mem_req && !irq && !code_in_ready && !code_out_valid;
  endproperty
  a_prst: assert property (p_prst) else $error("engine active in process reset");
  property p_req; run && mem_req && !mem_ack |=> mem_req && $stable({mem_we, mem_addr, mem_wdata});
  endproperty
  a_req: assert property (p_req) else $error("memory request changed before ack");
  property p_irq; irq |=> !irq; endproperty
  a_irq: assert property (p_irq) else $error("interrupt longer than a cycle");
  property p_cnt; $past(rn) && $changed(field_serial_count) |->
    field_serial_count == $past(field_serial_count) + 8'h01; endproperty
  a_cnt: assert property (p_cnt) else $error("serial count jumped");
  property p_idx; $past(rn) && $changed(buffer_index) |->
    buffer_index == $past(buffer_index) + 2'h1; endproperty
  a_idx: assert property (p_idx) else $error("buffer index not cyclic");
  property p_stat; ent_wr && compress_mode |->
    mem_wdata[31:24] == field_serial_count && mem_wdata[23] == 1'b0 && mem_wdata[1:0] == 2'h1;
  endproperty
  a_stat: assert property (p_stat) else $error("bad status entry");
  property p_dec; run && !compress_mode && mem_req && mem_we |-> mem_wdata[0] && mem_addr == ent;
  endproperty
  a_dec: assert property (p_dec) else $error("bad consumed entry write");
  property p_dir; code_in_ready |-> compress_mode; endproperty
  a_dir: assert property (p_dir) else $error("code taken while decompressing");
  property p_out; run && code_out_valid && !code_out_ready |=>
    code_out_valid && $stable(code_out_data); endproperty
  a_out: assert property (p_out) else $error("code out word dropped");
endmodule

bind jcb_code_dma jcb_code_dma_checker u_chk (
  .clk(clk), .sys_rst(sys_rst), .global_hold_control(global_hold_control),
  .process_reset(process_reset), .compress_mode(compress_mode),
  .buffer_table_base_register(buffer_table_base_register), .code_in_ready(code_in_ready),
  .code_out_data(code_out_data), .code_out_valid(code_out_valid),
  .code_out_ready(code_out_ready), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
  .mem_wdata(mem_wdata), .mem_ack(mem_ack), .irq(irq),
  .field_serial_count(field_serial_count), .buffer_index(buffer_index)
);

// [test/jcb_mem_model.sv]
// Purpose: Host memory answering the engine, with a settable wait.
// Assumes: 1 KB of word-addressed memory; higher address bits ignored.
// Notes: Read data is scrambled outside the ack cycle so stale values never match.
`timescale 1ns/100ps
module jcb_mem_model (
  input wire logic clk,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic [3:0] lat,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  logic [31:0] mem [0:255];
  logic [3:0] wait_cnt = 4'h0;
  initial mem_ack = 1'b0;
  initial mem_rdata = 32'h0;
  // One access at a time; ack after lat extra cycles
  always @(posedge clk)
  begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (mem_req && !mem_ack && wait_cnt >= lat)
    begin
      mem_ack <= 1'b1;
      wait_cnt <= 4'h0;
      if (mem_we)
        mem[mem_addr[9:2]] <= mem_wdata;
      else
        mem_rdata <= mem[mem_addr[9:2]];
    end
    else if (mem_req && !mem_ack)
      wait_cnt <= wait_cnt + 4'h1;
  end
endmodule

// [test/jcb_code_dma_tb.sv]
// Purpose: Directed test of the code buffer DMA engine against a memory model.
// Assumes: Inputs change 2 ns after the rising edge.
// Notes: Failures come from strip overflow and from a late vertical sync.
`timescale 1ns/100ps
module jcb_code_dma_tb;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic hold_write = 1'b0;
  logic hold_value = 1'b0;
  logic process_reset = 1'b0;
  logic compress_mode = 1'b1;
  logic strip_overflow = 1'b0;
  logic frame_mode = 1'b0;
  logic vsync_trail = 1'b0;
  logic [31:0] table_base = 32'h0;
  logic [31:0] code_in_data = 32'h0;
  logic code_in_last = 1'b0;
  logic code_in_valid = 1'b0;
  logic code_out_ready = 1'b0;
  logic [3:0] lat = 4'h0;
  logic global_hold_control, code_in_ready, code_out_valid, mem_req, mem_we, mem_ack, irq;
  logic [31:0] code_out_data, mem_addr, mem_wdata, mem_rdata;
  logic [7:0] field_serial_count;
  logic [1:0] buffer_index;
  int bad_count = 0;
  int checks = 0;
  int irq_seen = 0;
  int n;

  // Clock and interrupt pulse counter
  always #10 clk = ~clk;
  always @(posedge clk) if (irq === 1'b1) irq_seen <= irq_seen + 1;

  jcb_code_dma u_dut (
    .clk(clk), .sys_rst(sys_rst), .hold_write(hold_write), .hold_value(hold_value),
    .global_hold_control(global_hold_control), .process_reset(process_reset),
    .compress_mode(compress_mode), .frame_mode(frame_mode),
    .buffer_table_base_register(table_base),
    .vsync_trail(vsync_trail), .strip_overflow(strip_overflow), .code_in_data(code_in_data),
    .code_in_last(code_in_last), .code_in_valid(code_in_valid), .code_in_ready(code_in_ready),
    .code_out_data(code_out_data), .code_out_valid(code_out_valid),
    .code_out_ready(code_out_ready), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .irq(irq),
    .field_serial_count(field_serial_count), .buffer_index(buffer_index), .busy()
  );
  jcb_mem_model u_mem (
    .clk(clk), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .lat(lat), .mem_ack(mem_ack), .mem_rdata(mem_rdata)
  );

  task automatic give_verdict;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // A handshake that never comes ends the run as a failure
  task automatic hang;
    bad_count++;
    give_verdict;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #2;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    u_mem.mem[a[9:2]] = d;
  endtask
  task automatic wait_ready;
    for (n = 0; n < 500 && code_in_ready !== 1'b1; n++)
      @(negedge clk);
    if (n == 500)
      hang;
  endtask
  // One code word; a gap cycle follows since words are never back to back
  task automatic send(input logic [31:0] d, input logic last);
    code_in_data = d;
    code_in_last = last;
    code_in_valid = 1'b1;
    wait_ready;
    @(posedge clk);
    #2 code_in_valid = 1'b0;
    cyc(1);
  endtask
  task automatic wait_irq(input int k);
    for (n = 0; n < 2000 && irq_seen < k; n++)
      @(posedge clk);
    if (irq_seen < k)
      hang;
    cyc(3);
  endtask

  // Main sequence: compress, failed unit, polling, then decompress with repeat
  initial
  begin
    cyc(3);
    sys_rst = 1'b0;
    cyc(1);
    chk(global_hold_control, 32'h0);
    for (int k = 0; k < 4; k++)
    begin
      wr(32'h40 + 4 * k, 32'h80 + 16 * k);
      wr(32'h80 + 16 * k, 32'h100 + 64 * k);
      wr(32'h84 + 16 * k, 32'h9);
    end
    wr(32'h84, 32'h2);
    wr(32'h88, 32'h300);
    wr(32'h8C, 32'h9);
    wr(32'h48, 32'h1);
    cyc(5);
    chk(mem_req, 32'h0);
    process_reset = 1'b1;
    table_base = 32'h40;
    hold_write = 1'b1;
    hold_value = 1'b1;
    cyc(1);
    hold_write = 1'b0;
    cyc(1);
    chk(global_hold_control, 32'h1);
    process_reset = 1'b0;
    send(32'hA0, 1'b0);
    send(32'hA1, 1'b0);
    send(32'hA2, 1'b1);
    wait_irq(1);
    chk(u_mem.mem[8'h40], 32'hA0);
    chk(u_mem.mem[8'hC0], 32'hA1);
    chk(u_mem.mem[8'hC1], 32'hA2);
    chk(u_mem.mem[8'h10], 32'h19);
    chk(field_serial_count, 32'h1);
    chk(buffer_index, 32'h1);
    // Overflow while waiting for code, slow memory
    lat = 4'h3;
    wait_ready;
    cyc(1);
    strip_overflow = 1'b1;
    cyc(1);
    strip_overflow = 1'b0;
    send(32'hB0, 1'b1);
    chk(irq_seen, 32'h1);
    send(32'hB1, 1'b0);
    send(32'hB2, 1'b1);
    wait_irq(2);
    chk(u_mem.mem[8'h50], 32'hB1);
    chk(u_mem.mem[8'h11], 32'h02000011);
    cyc(30);
    chk(buffer_index, 32'h2);
    chk(mem_addr, 32'h48);
    chk(irq_seen, 32'h2);
    wr(32'h48, 32'hA0);
    frame_mode = 1'b1;
    send(32'hC0, 1'b1);
    send(32'hC1, 1'b1);
    wait_irq(3);
    chk(u_mem.mem[8'h60], 32'hC0);
    chk(u_mem.mem[8'h61], 32'hC1);
    chk(u_mem.mem[8'h12], 32'h03000011);
    // Third sync edge inside a two-field unit means the codec ran late
    wait_ready;
    cyc(1);
    repeat (3)
    begin
      vsync_trail = 1'b1;
      cyc(1);
      vsync_trail = 1'b0;
      cyc(1);
    end
    send(32'hE0, 1'b1);
    send(32'hE1, 1'b1);
    chk(field_serial_count, 32'h5);
    chk(irq_seen, 32'h3);
    chk(u_mem.mem[8'h13], 32'hB0);
    // Decompress buffer 0; entry 1 still shows status so buffer 0 repeats
    process_reset = 1'b1;
    cyc(1);
    compress_mode = 1'b0;
    lat = 4'h0;
    wr(32'h40, 32'h80);
    wr(32'h100, 32'hD0);
    for (int j = 0; j < 4; j++)
    begin
      wr(32'h300 + 4 * j, 32'hD1 + j);
      wr(32'h140 + 4 * j, 32'hF0 + j);
    end
    cyc(1);
    process_reset = 1'b0;
    cyc(30);
    code_out_ready = 1'b1;
    for (int i = 0; i < 14; i++)
    begin
      for (n = 0; n < 500 && code_out_valid !== 1'b1; n++)
        @(negedge clk);
      if (n == 500)
        hang;
      chk(code_out_data, i < 10 ? 32'hD0 + i % 5 : 32'hF0 + i - 10);
      // Host frees buffer 1 while buffer 0 is being repeated
      if (i == 8)
      begin
        chk(irq_seen, 32'h4);
        chk(buffer_index, 32'h1);
        wr(32'h44, 32'h90);
      end
      @(posedge clk);
      @(negedge clk);
    end
    wait_irq(5);
    chk(irq_seen, 32'h5);
    chk(buffer_index, 32'h2);
    chk(u_mem.mem[8'h10], 32'h81);
    chk(u_mem.mem[8'h11], 32'h91);
    give_verdict;
  end
endmodule
